// *** src/hdb_pkg.sv ***
// How it works
// - Value bits 8,4,2,1 drive lines 4..1
// - Pattern read back as its plain value
// - Defaults hold clear pattern at 15
// - Host converts prefixed formats into plain value
// - High line floats, low line sinks
// - Pass pattern driven when all tests pass
// - Auto-clear returns port to clear pattern
// - Pattern held for width in 10 us steps
// - Clear pattern is the idle state
// - End-of-test mode strobes line 4
// - Busy modes drive line 4 during test
// - Immediate arm starts test at once
// - Falling start input begins test
// - Rising start input begins test
// - Either edge begins test
// - Two enabled limit tests with bounds
// - Second start request aborts testing
// - Lines 1-3 outlast line 4 by 20 us
// - Busy modes override clear bit of line 4
package hdb_pkg;

	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_CLR_PAT = 8'h04;
	localparam logic [7:0] ADDR_PASS    = 8'h08;
	localparam logic [7:0] ADDR_FAIL    = 8'h0c;
	localparam logic [7:0] ADDR_WIDTH   = 8'h10;
	localparam logic [7:0] ADDR_L1_UP   = 8'h14;
	localparam logic [7:0] ADDR_L1_LO   = 8'h18;
	localparam logic [7:0] ADDR_L2_UP   = 8'h1c;
	localparam logic [7:0] ADDR_L2_LO   = 8'h20;
	localparam logic [7:0] ADDR_CMD     = 8'h24;
	localparam logic [7:0] ADDR_STATUS  = 8'h28;

	// CTRL fields
	localparam int CTRL_AUTO  = 0;
	localparam int CTRL_LF_LO = 1;
	localparam int CTRL_ARM_LO = 3;
	localparam int CTRL_L1_EN = 5;
	localparam int CTRL_L2_EN = 6;
	// CMD fields
	localparam int CMD_START = 0;
	localparam int CMD_CLEAR = 1;

	localparam logic [6:0]  CTRL_RST  = 7'h00;
	localparam logic [3:0]  PAT_RST   = 4'hf;
	localparam logic [7:0]  FAIL_RST  = 8'hff;
	localparam logic [22:0] WIDTH_RST = 23'h00000a;
	localparam logic [31:0] UP_RST    = 32'h00000001;
	localparam logic [31:0] LO_RST    = 32'hffffffff;

	localparam int CLK_NS      = 10;
	localparam int STEP_US     = 10;
	localparam int SKEW_US     = 20;
	localparam int STEP_CYC    = STEP_US * 1000 / CLK_NS;
	localparam int SKEW_STEPS  = SKEW_US / STEP_US;

	typedef enum logic [1:0] {
		LF_STROBE  = 2'h0,
		LF_BUSY_HI = 2'h1,
		LF_BUSY_LO = 2'h2
	} hdb_line4_t;

	typedef enum logic [1:0] {
		ARM_NOW  = 2'h0,
		ARM_FALL = 2'h1,
		ARM_RISE = 2'h2,
		ARM_BOTH = 2'h3
	} hdb_arm_t;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_ARMED = 5'b00010,
		ST_TEST  = 5'b00100,
		ST_DRIVE = 5'b01000,
		ST_HOLD  = 5'b10000
	} hdb_state_t;

	typedef struct packed {
		logic               valid;
		logic signed [31:0] value;
	} hdb_meas_t;

endpackage

// *** src/hdb_port.sv ***
`timescale 1ns/1ns
module hdb_port
	import hdb_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Measurement result
	input  wire hdb_meas_t   meas,
	// Handler pins
	input  wire logic        start_of_test_input,
	input  wire logic [3:0]  line_i,
	output logic [3:0]       line_o,
	output logic [3:0]       line_oe_n
);

	logic [6:0]  ctrl_r;
	logic [3:0]  clr_pat_r;
	logic [3:0]  pass_pat_r;
	logic [7:0]  fail_pat_r;
	logic [22:0] width_r;
	logic [31:0] l1_up_r, l1_lo_r, l2_up_r, l2_lo_r;
	hdb_state_t  state_r, state_nxt;
	logic [3:0]  pat_r, pat_nxt;
	logic [9:0]  tick_r;
	logic [22:0] step_r;
	logic [3:0]  lines_nxt;
	logic [3:0]  line_s1_r, line_in_r;
	logic        start_s1_r, start_s2_r, start_s3_r;
	logic        pready_r, pslverr_r;
	logic [31:0] prdata_r, rd_nxt;
	logic        hit, wr_en, start_req, clear_req, edge_go, last_step;
	logic        fail1, fail2;
	hdb_line4_t  lf;
	hdb_arm_t    arm;

	assign lf  = hdb_line4_t'(ctrl_r[CTRL_LF_LO +: 2]);
	assign arm = hdb_arm_t'(ctrl_r[CTRL_ARM_LO +: 2]);
	assign wr_en = psel && penable && pready_r && pwrite && !pslverr_r;
	assign start_req = wr_en && paddr == ADDR_CMD && pwdata[CMD_START];
	assign clear_req = wr_en && paddr == ADDR_CMD && pwdata[CMD_CLEAR];

	// Register read mux and decode
	always_comb begin
		hit = 1'b1;
		rd_nxt = 32'h0;
		unique case (paddr)
			ADDR_CTRL:    rd_nxt = {25'h0, ctrl_r};
			ADDR_CLR_PAT: rd_nxt = {28'h0, clr_pat_r};
			ADDR_PASS:    rd_nxt = {28'h0, pass_pat_r};
			ADDR_FAIL:    rd_nxt = {24'h0, fail_pat_r};
			ADDR_WIDTH:   rd_nxt = {9'h0, width_r};
			ADDR_L1_UP:   rd_nxt = l1_up_r;
			ADDR_L1_LO:   rd_nxt = l1_lo_r;
			ADDR_L2_UP:   rd_nxt = l2_up_r;
			ADDR_L2_LO:   rd_nxt = l2_lo_r;
			ADDR_CMD:     rd_nxt = 32'h0;
			ADDR_STATUS:  rd_nxt = {19'h0, line_in_r, line_oe_n, state_r};
			default:      hit = 1'b0;
		endcase
	end

	// Zero-wait answer: ready and data are registered in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0;
		end else begin
			pready_r  <= psel && !penable;
			pslverr_r <= psel && !penable && !hit;
			prdata_r  <= (psel && !penable && hit && !pwrite) ? rd_nxt : 32'h0;
		end
	end

	// Configuration registers; the host turns prefixed formats into plain values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r     <= CTRL_RST;
			clr_pat_r  <= PAT_RST;
			pass_pat_r <= PAT_RST;
			fail_pat_r <= FAIL_RST;
			width_r    <= WIDTH_RST;
			l1_up_r    <= UP_RST;
			l1_lo_r    <= LO_RST;
			l2_up_r    <= UP_RST;
			l2_lo_r    <= LO_RST;
		end else if (wr_en) begin
			unique case (paddr)
				ADDR_CTRL:    ctrl_r <= pwdata[6:0];
				ADDR_CLR_PAT: clr_pat_r <= pwdata[3:0];
				ADDR_PASS:    pass_pat_r <= pwdata[3:0];
				ADDR_FAIL:    fail_pat_r <= pwdata[7:0];
				ADDR_WIDTH:   width_r <= pwdata[22:0];
				ADDR_L1_UP:   l1_up_r <= pwdata;
				ADDR_L1_LO:   l1_lo_r <= pwdata;
				ADDR_L2_UP:   l2_up_r <= pwdata;
				ADDR_L2_LO:   l2_lo_r <= pwdata;
				default:      ;
			endcase
		end
	end

	// Start input synchroniser and edge detect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_s1_r <= 1'b1;
			start_s2_r <= 1'b1;
			start_s3_r <= 1'b1;
			line_s1_r  <= 4'hf;
			line_in_r  <= 4'hf;
		end else begin
			start_s1_r <= start_of_test_input;
			start_s2_r <= start_s1_r;
			start_s3_r <= start_s2_r;
			line_s1_r  <= line_i;
			line_in_r  <= line_s1_r;
		end
	end

	always_comb begin
		unique case (arm)
			ARM_FALL: edge_go = !start_s2_r && start_s3_r;
			ARM_RISE: edge_go = start_s2_r && !start_s3_r;
			ARM_BOTH: edge_go = start_s2_r != start_s3_r;
			default:  edge_go = 1'b0;
		endcase
	end

	// Limit tests, signed compare against both bounds
	assign fail1 = ctrl_r[CTRL_L1_EN] && (meas.value > $signed(l1_up_r) ||
		meas.value < $signed(l1_lo_r));
	assign fail2 = ctrl_r[CTRL_L2_EN] && (meas.value > $signed(l2_up_r) ||
		meas.value < $signed(l2_lo_r));
	assign last_step = tick_r == 10'(STEP_CYC - 1) &&
		step_r == width_r + 23'(SKEW_STEPS - 1);

	always_comb begin
		state_nxt = state_r;
		pat_nxt = pat_r;
		unique case (state_r)
			ST_IDLE, ST_HOLD: begin
				if (start_req) begin
					state_nxt = (arm == ARM_NOW) ? ST_TEST : ST_ARMED;
				end else if (clear_req) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_ARMED: begin
				if (start_req) begin
					state_nxt = ST_IDLE;
				end else if (edge_go) begin
					state_nxt = ST_TEST;
				end
			end
			ST_TEST: begin
				if (start_req) begin
					state_nxt = ST_IDLE;
				end else if (meas.valid) begin
					state_nxt = ST_DRIVE;
					if (fail1) begin
						pat_nxt = fail_pat_r[3:0];
					end else if (fail2) begin
						pat_nxt = fail_pat_r[7:4];
					end else begin
						pat_nxt = pass_pat_r;
					end
				end
			end
			ST_DRIVE: begin
				if (start_req || clear_req) begin
					state_nxt = ST_IDLE;
				end else if (last_step) begin
					state_nxt = ctrl_r[CTRL_AUTO] ? ST_IDLE : ST_HOLD;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
			pat_r   <= PAT_RST;
		end else begin
			state_r <= state_nxt;
			pat_r   <= pat_nxt;
		end
	end

	// Pulse timing in 10 us steps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_r <= 10'h0;
			step_r <= 23'h0;
		end else if (state_r != ST_DRIVE) begin
			tick_r <= 10'h0;
			step_r <= 23'h0;
		end else if (tick_r == 10'(STEP_CYC - 1)) begin
			tick_r <= 10'h0;
			step_r <= step_r + 23'h1;
		end else begin
			tick_r <= tick_r + 10'h1;
		end
	end

	// Line levels; line 4 strobes one step late and ends one step early
	always_comb begin
		lines_nxt = clr_pat_r;
		if (state_r == ST_DRIVE) begin
			lines_nxt[2:0] = pat_r[2:0];
			if (step_r >= 23'h1 && step_r <= width_r) begin
				lines_nxt[3] = pat_r[3];
			end
		end else if (state_r == ST_HOLD) begin
			lines_nxt = pat_r;
		end
		if (lf != LF_STROBE) begin
			lines_nxt[3] = (state_r == ST_TEST) == (lf == LF_BUSY_HI);
		end
	end

	// Open-collector drive: high releases the line, low sinks it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_oe_n <= 4'hf;
			line_o    <= 4'h0;
		end else begin
			line_oe_n <= lines_nxt;
			line_o    <= 4'h0;
		end
	end

	assign pready  = pready_r;
	assign pslverr = pslverr_r;
	assign prdata  = prdata_r;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	now_start_a: assert property (state_r == ST_IDLE && start_req && arm == ARM_NOW
		|=> state_r == ST_TEST) else $error("immediate arm did not start test");
	fall_start_a: assert property (state_r == ST_ARMED && !start_req &&
		arm == ARM_FALL && $fell(start_s2_r) |=> state_r == ST_TEST)
		else $error("falling edge did not start test");
	rise_start_a: assert property (state_r == ST_ARMED && !start_req &&
		arm == ARM_RISE && $rose(start_s2_r) |=> state_r == ST_TEST)
		else $error("rising edge did not start test");
	both_start_a: assert property (state_r == ST_ARMED && !start_req &&
		arm == ARM_BOTH && $changed(start_s2_r) |=> state_r == ST_TEST)
		else $error("either edge did not start test");
	abort_test_a: assert property ((state_r == ST_TEST || state_r == ST_ARMED) &&
		start_req |=> state_r == ST_IDLE) else $error("second request did not abort");
	pass_pick_a: assert property (state_r == ST_TEST && !start_req && meas.valid &&
		!fail1 && !fail2 |=> pat_r == pass_pat_r) else $error("pass pattern not chosen");
	fail_first_a: assert property (state_r == ST_TEST && !start_req && meas.valid &&
		fail1 |=> pat_r == fail_pat_r[3:0]) else $error("first fail not preferred");
	busy_level_a: assert property (lf == LF_BUSY_HI && state_r == ST_TEST
		|=> line_oe_n[3]) else $error("busy level not driven");
	busy_idle_a: assert property (lf == LF_BUSY_LO && state_r == ST_IDLE
		|=> line_oe_n[3]) else $error("inverted busy idle not high");
	idle_clear_a: assert property (lf == LF_STROBE && state_r == ST_IDLE && $stable(clr_pat_r)
		|=> line_oe_n == $past(clr_pat_r)) else $error("idle lines differ from clear pattern");
	strobe_skew_a: assert property (lf == LF_STROBE && state_r == ST_DRIVE && step_r == 23'h0
		|=> line_oe_n[3] == clr_pat_r[3] && line_oe_n[2:0] == pat_r[2:0])
		else $error("line 4 not delayed against lines 1-3");
	read_pat_a: assert property (psel && !penable && !pwrite && paddr == ADDR_CLR_PAT
		|=> prdata == {28'h0, $past(clr_pat_r)}) else $error("pattern read back wrong");
	hold_full_a: assert property (state_r == ST_HOLD && lf == LF_STROBE
		|=> line_oe_n == pat_r) else $error("held pattern not on lines");
	auto_clear_a: assert property (state_r == ST_DRIVE && last_step &&
		!start_req && !clear_req && ctrl_r[CTRL_AUTO] |=> state_r == ST_IDLE)
		else $error("auto-clear did not return to idle");
	hold_keep_a: assert property (state_r == ST_DRIVE && last_step &&
		!start_req && !clear_req && !ctrl_r[CTRL_AUTO] |=> state_r == ST_HOLD)
		else $error("pattern not held without auto-clear");
	step_count_a: assert property (state_r == ST_DRIVE && !last_step &&
		tick_r == 10'(STEP_CYC - 1) && !start_req && !clear_req |=> state_r == ST_DRIVE &&
		step_r == $past(step_r) + 23'h1) else $error("pulse step not counted");
	strobe_on_a: assert property (lf == LF_STROBE && state_r == ST_DRIVE &&
		step_r == 23'h1 && width_r != 23'h0 |=> line_oe_n[3] == pat_r[3])
		else $error("strobe level not driven on line 4");
	strobe_end_a: assert property (lf == LF_STROBE && state_r == ST_DRIVE &&
		step_r > width_r && !(wr_en && paddr == ADDR_CLR_PAT)
		|=> line_oe_n == {clr_pat_r[3], pat_r[2:0]}) else $error("line 4 not released early");
	busy_low_a: assert property (lf == LF_BUSY_LO && state_r == ST_TEST
		|=> !line_oe_n[3]) else $error("inverted busy level not driven");
	busy_rest_a: assert property (lf == LF_BUSY_HI && state_r != ST_TEST
		|=> !line_oe_n[3]) else $error("busy idle not low");
	fail_second_a: assert property (state_r == ST_TEST && meas.valid &&
		!start_req && !fail1 && fail2 |=> pat_r == fail_pat_r[7:4]) else $error("second fail not used");
	no_limit_a: assert property (state_r == ST_TEST && meas.valid && !start_req &&
		!ctrl_r[CTRL_L1_EN] && !ctrl_r[CTRL_L2_EN] |=> pat_r == pass_pat_r)
		else $error("disabled limits did not pass");
	clear_cmd_a: assert property ((state_r == ST_DRIVE || state_r == ST_HOLD) &&
		clear_req && !start_req |=> state_r == ST_IDLE) else $error("clear did not return to idle");

endmodule

// *** tb/hdb_handler.sv ***
`timescale 1ns/1ns
module hdb_handler (
	// Clock
	input  wire logic       pclk,
	// Handler pins
	input  wire logic [3:0] line_o,
	input  wire logic [3:0] line_oe_n,
	output logic            start_of_test_input,
	output logic [3:0]      line_lvl
);
	// Released open-collector lines float up to the pull-up level
	assign line_lvl = ~line_oe_n & line_o | line_oe_n;
	initial start_of_test_input = 1'b1;
	// Moves the start pin just after a clock edge
	task automatic pin(input logic v);
		@(posedge pclk);
		start_of_test_input <= v;
	endtask
endmodule

// *** tb/handler_digital_io_binning_test.sv ***
`timescale 1ns/1ns
module handler_digital_io_binning_test import hdb_pkg::*; ;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, start_pin, perr, l4, p;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  line_o, line_oe_n, lvl, pat;
	hdb_meas_t   meas;
	int          miscompares, checks_done, v, md, arm, en;
	int unsigned xs_st = 37;
	int          bnd[6] = '{3, 4, -3, -4, 6, -7};
	hdb_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .meas(meas), .start_of_test_input(start_pin), .line_i(lvl),
		.line_o(line_o), .line_oe_n(line_oe_n));
	hdb_handler u_hnd (.pclk(pclk), .line_o(line_o), .line_oe_n(line_oe_n),
		.start_of_test_input(start_pin), .line_lvl(lvl));
	function automatic int unsigned xs();
		xs_st ^= xs_st << 13;
		xs_st ^= xs_st >> 17;
		xs_st ^= xs_st << 5;
		return xs_st;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic pulse(input int val);
		@(posedge pclk);
		meas <= '{1'b1, val};
		@(posedge pclk);
		meas.valid <= 1'b0;
	endtask
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		#800000;
		miscompares++;
		give_verdict();
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		meas = '0;
		cyc(6);
		presetn <= 1'b1;
		cyc(1);
		chk(lvl, 4'hf);
		apb(0, ADDR_CLR_PAT, 0);
		chk(rd, 32'hf);
		apb(0, 8'h80, 0);
		chk(perr, 1'b1);
		apb(1, ADDR_CLR_PAT, 32'ha);
		apb(1, ADDR_PASS, 32'h5);
		apb(1, ADDR_FAIL, 32'h63);
		apb(1, ADDR_WIDTH, 32'h1);
		apb(1, ADDR_L1_UP, 32'h3);
		apb(1, ADDR_L1_LO, 32'hfffffffd);
		apb(1, ADDR_L2_UP, 32'h6);
		apb(1, ADDR_L2_LO, 32'hfffffffa);
		apb(0, ADDR_PASS, 0);
		chk(rd, 32'h5);
		for (int i = 0; i < 12; i++) begin
			md = i % 3;
			arm = i % 4;
			en = (i / 3) % 4;
			v = i < 6 ? bnd[i] : int'(xs() % 17) - 8;
			pat = en[0] && (v > 3 || v < -3) ? 4'h3 : en[1] && (v > 6 || v < -6) ? 4'h6 : 4'h5;
			p = arm == 2 ? 1'b0 : arm == 1 ? 1'b1 : 1'((i / 4) % 2);
			l4 = md == 0 ? 1'b1 : md == 2;
			u_hnd.pin(p);
			apb(1, ADDR_CTRL, 1 | md << 1 | arm << 3 | en << 5);
			apb(1, ADDR_CMD, 1);
			apb(0, ADDR_STATUS, 0);
			chk(rd[4:0], arm == 0 ? 5'h04 : 5'h02);
			if (arm != 0) begin
				u_hnd.pin(~p);
				cyc(6);
				apb(0, ADDR_STATUS, 0);
				chk(rd[4:0], 5'h04);
			end
			chk(lvl[3], md == 2 ? 1'b0 : 1'b1);
			pulse(v);
			cyc(300);
			chk(lvl, {l4, pat[2:0]});
			cyc(1000);
			chk(lvl, {md == 0 ? pat[3] : l4, pat[2:0]});
			cyc(1000);
			chk(lvl, {l4, pat[2:0]});
			cyc(1000);
			chk(lvl, {l4, 3'h2});
		end
		apb(1, ADDR_CTRL, 32'h20);
		apb(1, ADDR_CMD, 1);
		apb(1, ADDR_CMD, 1);
		apb(0, ADDR_STATUS, 0);
		chk(rd[4:0], 5'h01);
		apb(1, ADDR_CMD, 1);
		pulse(9);
		cyc(3300);
		chk(lvl, 4'h3);
		apb(1, ADDR_CMD, 2);
		cyc(3);
		chk(lvl, 4'ha);
		chk(line_o, 4'h0);
		apb(0, ADDR_STATUS, 0);
		chk(rd[12:5], 8'haa);
		give_verdict();
	end
endmodule
